// ==== core/dsba_pkg.sv ====
// Constants, operation codes and lane layout for the DSP byte datapath.
// Assumes a core that supplies 32-bit register operands each cycle.
// Behaviour
// - Halving add forms a 9-bit zero-extended sum per byte and keeps bits 8..1.
// - The rounded halving add adds one to the 9-bit sum before the shift.
// - Operands are four unsigned byte lanes and results stay in their lane.
// - The halving add leaves the DSP status and control register untouched.
// - No operation raises an exception because of data values.
// - Shift-insert shifts operand two left and fills low bits from operand one.
// - Byte align ORs operand two shifted left and operand one shifted right.
// - Byte position is a 2-bit unsigned immediate from zero to three.
// - Bit mirror reverses the sixteen bits of operand one's low half.
// - Bit mirror forces the upper destination half to zero.
// - Absent extension gives reserved fault, disabled gives DSP fault, no write.
package dsba_pkg;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned LANE_W  = 8;
  localparam int unsigned LANES   = 4;
  localparam int unsigned HALF_W  = 16;
  localparam int unsigned SHAMT_W = 5;
  localparam int unsigned BPOS_W  = 2;
  localparam int unsigned OP_W    = 3;
  localparam logic [DATA_W-1:0] RESULT_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    DSBA_OP_NONE  = 3'h0,
    DSBA_OP_HADD  = 3'h1,
    DSBA_OP_HADDR = 3'h3,
    DSBA_OP_INS   = 3'h2,
    DSBA_OP_ALIGN = 3'h6,
    DSBA_OP_MIRR  = 3'h7
  } dsba_op_e;
endpackage

// ==== core/dsba_lane_add.sv ====
// One byte lane of the halving unsigned add.
// Assumes unsigned byte operands; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module dsba_lane_add (
  // Lane operands
  input  wire logic [7:0] laneA,
  input  wire logic [7:0] laneB,
  input  wire logic       roundEn,
  // Halved result
  output logic      [7:0] laneRes
);
  logic [8:0] sum;

  // Nine-bit sum, optional +1, keep bits 8..1
  always_comb begin
    sum = {1'b0, laneA} + {1'b0, laneB} + {8'h00, roundEn};
    laneRes = sum[8:1];
  end
endmodule
`default_nettype wire

// ==== core/dsba_datapath.sv ====
// Execute-stage datapath for halving byte add, shift-insert, byte align
// and bit mirror. Assumes operands arrive with a valid strobe from issue.
`timescale 1ns/1ps
`default_nettype none
module dsba_datapath (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Issue
  input  wire logic        issueValid,
  input  wire logic [2:0]  opSel,
  input  wire logic [31:0] operandOne,
  input  wire logic [31:0] operandTwo,
  input  wire logic [4:0]  shiftAmount,
  input  wire logic [1:0]  bytePosition,
  // Extension state
  input  wire logic        extPresent,
  input  wire logic        extEnable,
  // Writeback and faults
  output logic             writeEn_r,
  output logic      [31:0] result_r,
  output logic             reservedFault_r,
  output logic             dspDisabledFault_r,
  output logic             dspStatusWrite_r
);
  logic [31:0] haddRes;
  logic [31:0] insRes;
  logic [31:0] alignRes;
  logic [31:0] mirrRes;
  logic [31:0] result_nxt;
  logic        roundEn;
  logic        knownOp;

  // Bit reversal of a halfword
  function automatic logic [15:0] mirror16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[15-i] = v[i];
    end
    return r;
  endfunction

  assign roundEn = (opSel == dsba_pkg::DSBA_OP_HADDR);

  // Four independent lanes, each result in its own lane
  generate
    for (genvar g = 0; g < dsba_pkg::LANES; g++) begin : gLane
      dsba_lane_add uLane (
        .laneA  (operandOne[g*8 +: 8]),
        .laneB  (operandTwo[g*8 +: 8]),
        .roundEn(roundEn),
        .laneRes(haddRes[g*8 +: 8])
      );
    end
  endgenerate

  // Shift-insert; low bits come from the bottom of operand one, not
  // its top, so a plain funnel shift cannot be reused here
  always_comb begin
    logic [31:0] fillMask;
    fillMask = ~(32'hFFFF_FFFF << shiftAmount);
    insRes = (operandTwo << shiftAmount) | (operandOne & fillMask);
  end

  // Byte align; positions 0 and 2 are free to give this formula too,
  // which keeps the shifter shared and the result defined
  always_comb begin
    logic [63:0] cat;
    cat = 64'h0;
    cat = {operandTwo, operandOne} << {bytePosition, 3'b000};
    alignRes = cat[63:32];
  end

  assign mirrRes = {16'h0000, mirror16(operandOne[15:0])};

  // Result select; no data-dependent fault path exists
  always_comb begin
    knownOp = 1'b1;
    result_nxt = dsba_pkg::RESULT_RST;
    case (opSel)
      dsba_pkg::DSBA_OP_HADD,
      dsba_pkg::DSBA_OP_HADDR: result_nxt = haddRes;
      dsba_pkg::DSBA_OP_INS: result_nxt = insRes;
      dsba_pkg::DSBA_OP_ALIGN: result_nxt = alignRes;
      dsba_pkg::DSBA_OP_MIRR: result_nxt = mirrRes;
      default: knownOp = 1'b0;
    endcase
  end

  // Writeback, gated by extension state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      writeEn_r <= 1'b0;
      result_r  <= dsba_pkg::RESULT_RST;
    end else begin
      writeEn_r <= issueValid && knownOp && extPresent && extEnable;
      result_r  <= result_nxt;
    end
  end

  // Faults: absent extension takes priority over disabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reservedFault_r    <= 1'b0;
      dspDisabledFault_r <= 1'b0;
    end else begin
      reservedFault_r    <= issueValid && knownOp && !extPresent;
      dspDisabledFault_r <= issueValid && knownOp && extPresent
                            && !extEnable;
    end
  end

  // These operations never touch DSP status and control
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dspStatusWrite_r <= 1'b0;
    end else begin
      dspStatusWrite_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== bench/dsba_asserts.sv ====
// Checker on the datapath ports.
// Assumes one clock and an active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dsba_asserts (
  input wire logic        clk, resetn, issueValid, extPresent, extEnable,
  input wire logic [2:0]  opSel,
  input wire logic [31:0] operandOne, operandTwo, result_r,
  input wire logic [4:0]  shiftAmount,
  input wire logic [1:0]  bytePosition,
  input wire logic        writeEn_r, reservedFault_r, dspDisabledFault_r,
  input wire logic        dspStatusWrite_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Known op issued with the extension usable
  wire known = opSel inside {3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  wire runOk = issueValid && known && extPresent && extEnable;
  chk_write_pulse: assert property (runOk |=> writeEn_r
    && !reservedFault_r && !dspDisabledFault_r) else $error("no write");
  chk_idle_quiet: assert property (!issueValid |=> !writeEn_r)
    else $error("stray write");
  chk_status_kept: assert property (!dspStatusWrite_r)
    else $error("status written");
  chk_reserved_hit: assert property (issueValid && known && !extPresent
    |=> reservedFault_r && !writeEn_r) else $error("no reserved fault");
  chk_disabled_hit: assert property (issueValid && known && extPresent
    && !extEnable |=> dspDisabledFault_r && !writeEn_r) else $error("no fault");
  chk_halve_lane: assert property (runOk && opSel[0] && !opSel[2] |=>
    result_r[31:24] == 8'((9'h000 + $past(operandOne[31:24])
    + $past(operandTwo[31:24]) + $past(opSel[1])) >> 1)) else $error("lane");
  chk_align_one: assert property (runOk && opSel == 3'h6 && bytePosition
    == 2'h1 |=> result_r == {$past(operandTwo[23:0]),
    $past(operandOne[31:24])}) else $error("align");
  chk_mirror_half: assert property (runOk && opSel == 3'h7 |=>
    result_r[31:16] == 16'h0000 && result_r[15] == $past(operandOne[0])
    && result_r[0] == $past(operandOne[15])) else $error("mirror");
endmodule
bind dsba_datapath dsba_asserts i_dsba_asserts (.*);
`default_nettype wire

// ==== bench/dsba_issuer.sv ====
// Issue-stage model feeding operands.
// Assumes the bench calls go after reset.
`timescale 1ns/1ps
`default_nettype none
module dsba_issuer (
  input  wire logic        clk,
  output var  logic        issueValid, extPresent, extEnable,
  output var  logic [2:0]  opSel,
  output var  logic [31:0] operandOne, operandTwo,
  output var  logic [4:0]  shiftAmount,
  output var  logic [1:0]  bytePosition
);
  initial {issueValid, opSel, operandOne, operandTwo} = '0;
  initial {shiftAmount, bytePosition, extPresent, extEnable} = 9'h003;
  // One issue; operands scrambled after so stale values never pass
  task automatic go(input logic [1:0] e, input logic [2:0] op,
      input logic [31:0] a, b, input logic [4:0] s, input logic [1:0] p);
    @(posedge clk) #1;
    {extPresent, extEnable, opSel, shiftAmount} = {e, op, s};
    {operandOne, operandTwo, bytePosition} = {a, b, p};
    issueValid = 1'b1;
    @(posedge clk) #1;
    {issueValid, operandOne, operandTwo} = {1'b0, ~a, ~b};
  endtask
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the byte datapath.
// Assumes the issuer model and bound checker.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk, resetn, issueValid, extPresent, extEnable, writeEn_r;
  logic        reservedFault_r, dspDisabledFault_r, dspStatusWrite_r;
  logic [2:0]  opSel;
  logic [31:0] operandOne, operandTwo, result_r;
  logic [4:0]  shiftAmount;
  logic [1:0]  bytePosition;
  int          n_mismatch, n_checks;
  dsba_datapath i_dsba_datapath (.*);
  dsba_issuer i_dsba_issuer (.*);
  task automatic chk(input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Issue, then judge pulses and result a cycle later
  task automatic run(input logic [1:0] e, input logic [2:0] op,
      input logic [31:0] a, b, x, input logic [4:0] s, input logic [1:0] p);
    i_dsba_issuer.go(e, op, a, b, s, p);
    chk({writeEn_r, reservedFault_r, dspDisabledFault_r, dspStatusWrite_r},
      {e == 2'h3 && op != 3'h0, !e[1], e == 2'h2, 1'b0});
    if (e == 2'h3 && op != 3'h0) chk(result_r, x);
  endtask
  task automatic t_ops;
    run(2'h3, 3'h1, 32'hFFFF_0101, 32'hFF01_0000, 32'hFF80_0000, 0, 0);
    run(2'h3, 3'h3, 32'hFFFF_0101, 32'hFF01_0000, 32'hFF80_0101, 0, 0);
    run(2'h3, 3'h2, 32'h5, 32'h8000_0001, 32'h8000_0005, 5'h1F, 0);
    run(2'h3, 3'h2, 32'h5, 32'h8000_0001, 32'h8000_0001, 5'h00, 0);
    run(2'h3, 3'h6, 32'hAABB_CCDD, 32'h1122_3344, 32'h2233_44AA, 0, 1);
    run(2'h3, 3'h6, 32'hAABB_CCDD, 32'h1122_3344, 32'h44AA_BBCC, 0, 3);
    run(2'h3, 3'h7, 32'hDEAD_80F1, 0, 32'h0000_8F01, 0, 0);
    $display("test ops done");
  endtask
  task automatic t_faults;
    run(2'h0, 3'h1, 0, 0, 0, 0, 0);
    run(2'h2, 3'h7, 0, 0, 0, 0, 0);
    run(2'h3, 3'h0, 0, 0, 0, 0, 0);
    $display("test faults done");
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    resetn = 0;
    repeat (20) @(posedge clk);
    #1 resetn = 1;
    t_ops();
    t_faults();
    complete_run();
  end
  // Hang guard
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
